// ===== src/tws_host.sv
// controller end: APB registers drive the three-wire link
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
module tws_host #(
  parameter int HALF_CYC = tws_pkg::HALF_CYC,
  parameter int PROG_CYC = tws_pkg::PROG_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  tws_if.host              link
);
  tws_pkg::tws_hstate_t st_q;
  logic [31:0] cmd_q;
  logic [4:0]  nbits_q;
  logic [4:0]  bitn_q;
  logic [15:0] sh_q;
  logic [31:0] cnt_q;
  logic [7:0]  rdata_q;
  logic [3:0]  rbit_q;
  logic        busy_q;
  logic        phase_q;
  logic        en_q;
  logic        ck_q;
  logic        dq_q;
  logic        doe_q;
  logic        start;
  logic [1:0]  op;

  wire acc  = psel && penable;
  wire tick = (cnt_q == 32'(HALF_CYC - 1));
  assign op = cmd_q[1:0];
  assign start = acc && pwrite && (paddr == tws_pkg::REG_CMD) && !busy_q;

  assign pready  = 1'b1;
  assign pslverr = acc && !(paddr == tws_pkg::REG_CMD || paddr == tws_pkg::REG_STATUS
                   || paddr == tws_pkg::REG_RDATA);
  always_comb begin
    unique case (paddr)
      tws_pkg::REG_CMD:    prdata = cmd_q;
      tws_pkg::REG_STATUS: prdata = {31'h0, busy_q};
      tws_pkg::REG_RDATA:  prdata = {24'h0, rdata_q};
      default:             prdata = 32'h0;
    endcase
  end

  // link sequencer; erase/write use the mode bit left in the shifter when op is write-only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= tws_pkg::TWS_IDLE;
      cmd_q <= '0; busy_q <= 1'b0; cnt_q <= '0; phase_q <= 1'b0;
      en_q <= 1'b1; ck_q <= 1'b0; dq_q <= 1'b1; doe_q <= 1'b0;
      sh_q <= '0; nbits_q <= '0; bitn_q <= '0; rdata_q <= '0; rbit_q <= '0;
    end else begin
      cnt_q <= tick ? 32'h0 : cnt_q + 32'h1;
      unique case (st_q)
        tws_pkg::TWS_IDLE: if (start) begin
          cmd_q  <= pwdata;
          busy_q <= 1'b1;
          cnt_q  <= '0;
          phase_q <= 1'b0;
          bitn_q <= '0;
          doe_q  <= 1'b1;
          if (pwdata[1:0] == tws_pkg::OP_READ) begin
            sh_q <= {8'h0, 1'b0, pwdata[tws_pkg::CMD_ADDR_LO +: 7]}; // see R3
            nbits_q <= 5'd8;
            st_q <= tws_pkg::TWS_SHIFT;
          end else if (pwdata[1:0] == tws_pkg::OP_WRITE) begin
            nbits_q <= 5'd0; // see R14
            st_q <= tws_pkg::TWS_SHIFT;
          end else begin
            sh_q <= {1'b1, pwdata[tws_pkg::CMD_ADDR_LO +: 7],
                     (pwdata[1:0] == tws_pkg::OP_ERASE) ? tws_pkg::ERASED_WORD
                     : pwdata[tws_pkg::CMD_DATA_LO +: 8]}; // see R4 see R16
            nbits_q <= 5'd16;
            st_q <= tws_pkg::TWS_SHIFT;
          end
        end
        tws_pkg::TWS_SHIFT: if (tick) begin // see R2
          if (bitn_q == nbits_q) begin
            // drive the operation level, then select
            dq_q  <= (op == tws_pkg::OP_READ) ? 1'b1 : (op != tws_pkg::OP_WRITE);
            doe_q <= (op != tws_pkg::OP_READ); // see R5 see R11
            st_q  <= tws_pkg::TWS_SEL;
            phase_q <= 1'b0;
          end else if (!phase_q) begin
            dq_q <= sh_q[0];
            ck_q <= 1'b0;
            phase_q <= 1'b1;
          end else if (!ck_q) begin
            ck_q <= 1'b1; // see R20
          end else begin
            ck_q <= 1'b0;
            sh_q <= {1'b0, sh_q[15:1]};
            bitn_q <= bitn_q + 5'd1;
            phase_q <= 1'b0;
          end
        end
        tws_pkg::TWS_SEL: if (tick) begin
          en_q <= 1'b0; // see R1
          rbit_q <= '0;
          st_q <= tws_pkg::TWS_PULSE;
        end
        tws_pkg::TWS_PULSE: if (tick) begin
          if (!ck_q) begin
            ck_q <= 1'b1; // see R12
          end else begin
            ck_q <= 1'b0;
            if (op == tws_pkg::OP_READ) begin
              if (rbit_q != 4'd0) begin
                rdata_q <= {link.data_line, rdata_q[7:1]}; // see R7
              end
              rbit_q <= rbit_q + 4'd1;
              if (rbit_q == 4'd8) st_q <= tws_pkg::TWS_DONE;
            end else begin
              cnt_q <= '0;
              st_q <= tws_pkg::TWS_HOLD;
            end
          end
        end
        tws_pkg::TWS_HOLD: if (cnt_q == 32'(PROG_CYC - 1)) begin
          st_q <= tws_pkg::TWS_DONE; // see R19 see R13
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
        tws_pkg::TWS_DONE: begin
          en_q <= 1'b1;
          doe_q <= 1'b0;
          dq_q <= 1'b1;
          busy_q <= 1'b0;
          st_q <= tws_pkg::TWS_IDLE;
        end
        default: st_q <= tws_pkg::TWS_IDLE;
      endcase
    end
  end

  assign link.enable_hi    = en_q;
  assign link.shift_clk    = ck_q;
  assign link.data_host_o  = dq_q;
  assign link.data_host_oe = doe_q;
endmodule : tws_host

// ===== src/tws_pkg.sv
// shared constants and types for the three-wire serial nonvolatile memory link
package tws_pkg;
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int WORDS       = 128;
  localparam int CMD_W       = 16;
  localparam int RD_CMD_W    = 8;
  // bit positions after a full reprogram command has been shifted in (lsb first)
  localparam int MODE_POS    = 15;
  localparam int ADDR_LO     = 8;
  localparam int DATA_LO     = 0;
  localparam logic [7:0] ERASED_WORD = 8'hff;
  // bus side
  localparam int CLK_MHZ      = 20;
  localparam int HALF_US      = 5;
  localparam int HALF_CYC     = HALF_US * CLK_MHZ;
  localparam int PROG_US      = 10000;
  localparam int PROG_CYC     = PROG_US * CLK_MHZ;
  // controller register offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  // command codes in REG_CMD[1:0]
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_ERASE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_REPROG = 2'h3;
  localparam int CMD_ADDR_LO  = 8;
  localparam int CMD_DATA_LO  = 16;

  typedef enum logic [2:0] {
    TWS_IDLE  = 3'b000,
    TWS_SHIFT = 3'b001,
    TWS_SEL   = 3'b010,
    TWS_PULSE = 3'b011,
    TWS_HOLD  = 3'b100,
    TWS_DONE  = 3'b101
  } tws_hstate_t;
endpackage : tws_pkg

// ===== src/tws_if.sv
// three-wire link between the memory device and its controller
`timescale 1ns/100ps
interface tws_if;
  logic enable_hi;   // high = reset and serial input, low = selected
  logic shift_clk;
  logic data_host_o;
  logic data_host_oe;
  logic data_dev_o;
  logic data_dev_oe;
  logic data_line;
  // open-drain style resolution with pull-up
  assign data_line = (data_host_oe ? data_host_o : 1'b1) & (data_dev_oe ? data_dev_o : 1'b1);
  modport dev  (input enable_hi, input shift_clk, input data_line,
                output data_dev_o, output data_dev_oe);
  modport host (output enable_hi, output shift_clk, output data_host_o,
                output data_host_oe, input data_line);
endinterface : tws_if

// ===== src/tws_sync.sv
// three-stage synchroniser with agreement filter for link pins
`timescale 1ns/100ps
module tws_sync #(
  parameter int   W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // stages start at the idle pin levels so no false edge follows reset
      s1_q <= rst_val;
      s2_q <= rst_val;
      s3_q <= rst_val;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the second and third stage agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_o <= rst_val;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : tws_sync

// ===== src/tws_device.sv
// memory device end: shift register, word array, read-out and programming
// Summary of operation
// R1: enable high resets; low selects device
// R2: command shifted in before enable falls
// R3: read command: seven address bits, mode zero
// R4: reprogram: data, address, mode one
// R5: mode zero starts read; data ignored
// R6: first pulse loads word, drives bit
// R7: each further pulse shifts next bit
// R8: enable rising releases the data line
// R9: erase sets ones; write clears zeros
// R10: reprogram only with mode bit one
// R11: data level at select picks operation
// R12: programming starts at start pulse fall
// R13: enable high ends erase or write
// R14: mode bit survives erase for write
// R15: write without erase ANDs contents
// R16: controller loads ones before erase
// R17: enable high resets sequencing, keeps shifter
// R18: power-up sets rest state internally
// R19: controller holds enable for programming time
// R20: enable high shifts data on rising clock
`timescale 1ns/100ps
module tws_device #(
  parameter int AW = tws_pkg::ADDR_W,
  parameter int DW = tws_pkg::DATA_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  tws_if.dev                 link,
  output logic               prog_active,
  output logic               read_active,
  output logic [AW-1:0]      last_addr
);
  localparam int SW = tws_pkg::CMD_W;

  logic [DW-1:0] mem_q [tws_pkg::WORDS];
  logic [SW-1:0] shreg_q;
  logic [2:0]    pins;
  logic          en_hi;
  logic          sclk;
  logic          din;
  logic          en_hi_q;
  logic          sclk_q;
  logic          op_sel_q;      // level of data at enable fall: 1 erase, 0 write
  logic          reading_q;
  logic          loaded_q;
  logic          prog_q;
  logic          pulse_seen_q;
  logic          dout_q;
  logic          doe_q;
  logic [AW-1:0] addr_q;

  // address and mode positions are the same for both command lengths; read commands sit high
  function automatic logic [AW-1:0] cmd_addr(input logic [SW-1:0] s);
    cmd_addr = s[tws_pkg::ADDR_LO +: AW];
  endfunction : cmd_addr

  tws_sync #(.W(3)) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_i   ({link.enable_hi, link.shift_clk, link.data_line}),
    .rst_val (3'h5),   // idle pins: enable high, clock low, line pulled up
    .level_o (pins)
  );
  assign en_hi = pins[2];
  assign sclk  = pins[1];
  assign din   = pins[0];

  wire en_fall  = en_hi_q && !en_hi;
  wire clk_rise = !sclk_q && sclk;
  wire clk_fall = sclk_q && !sclk;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_hi_q <= 1'b1;
      sclk_q  <= 1'b0;
    end else begin
      en_hi_q <= en_hi;
      sclk_q  <= sclk;
    end
  end

  // shift register: serial input while enabled high; loaded/shifted in read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shreg_q <= '0;
    end else if (en_hi && clk_rise) begin
      shreg_q <= {din, shreg_q[SW-1:1]}; // see R20 see R2 see R17
    end else if (!en_hi && reading_q && clk_rise) begin
      if (!loaded_q) begin
        shreg_q[DW-1:0] <= mem_q[addr_q]; // see R6
      end else begin
        shreg_q[DW-1:0] <= {1'b1, shreg_q[DW-1:1]}; // see R7
      end
    end
  end

  // sequencing flip-flops, all held in reset while enable is high
  always_ff @(posedge clk) begin
    if (!rst_n || en_hi) begin // see R18 see R17 see R1
      reading_q    <= 1'b0;
      loaded_q     <= 1'b0;
      prog_q       <= 1'b0;
      pulse_seen_q <= 1'b0;
      op_sel_q     <= 1'b0;
      addr_q       <= '0;
    end else begin
      if (en_fall) begin
        op_sel_q <= din; // see R11
        addr_q   <= cmd_addr(shreg_q);
        reading_q <= !shreg_q[tws_pkg::MODE_POS]; // see R5 see R10 see R14
      end
      if (reading_q && clk_rise) begin
        loaded_q <= 1'b1;
      end
      if (!reading_q && shreg_q[tws_pkg::MODE_POS] && clk_fall && !pulse_seen_q) begin
        pulse_seen_q <= 1'b1;
        prog_q       <= 1'b1; // see R12
      end
    end
  end

  // cell change while programming lasts; enable high stops it at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < tws_pkg::WORDS; i++) begin
        mem_q[i] <= tws_pkg::ERASED_WORD;
      end
    end else if (prog_q && !en_hi) begin // see R13
      if (op_sel_q) begin
        // erase raises the bits loaded as one; an all-ones load sets the whole word to ones
        mem_q[addr_q] <= mem_q[addr_q] | shreg_q[tws_pkg::DATA_LO +: DW]; // see R9 see R16
      end else begin
        mem_q[addr_q] <= mem_q[addr_q] & shreg_q[tws_pkg::DATA_LO +: DW]; // see R9 see R15
      end
    end
  end

  // data line driver: on after first pulse ends, off when enable rises
  always_ff @(posedge clk) begin
    if (!rst_n || en_hi) begin
      doe_q  <= 1'b0; // see R8
      dout_q <= 1'b1;
    end else if (reading_q && loaded_q && clk_fall) begin
      doe_q  <= 1'b1; // see R6
      dout_q <= shreg_q[0];
    end
  end

  assign link.data_dev_o  = dout_q;
  assign link.data_dev_oe = doe_q;
  assign prog_active      = prog_q;
  assign read_active      = reading_q;
  assign last_addr        = addr_q;
endmodule : tws_device

// ===== test/tws_chk.sv
// assertion checker watching the three-wire link between controller and memory
`timescale 1ns/100ps
module tws_chk #(
  parameter int HALF_CYC = tws_pkg::HALF_CYC,
  parameter int PROG_CYC = tws_pkg::PROG_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable_hi,
  input wire logic shift_clk,
  input wire logic data_host_o,
  input wire logic data_host_oe,
  input wire logic data_dev_o,
  input wire logic data_dev_oe,
  input wire logic data_line
);
  logic [31:0] hi_q;
  logic [31:0] low_q;
  logic [7:0]  fall_q;
  logic [4:0]  nbit_q;
  logic        dev_seen_q;
  always_ff @(posedge clk) begin
    if (!rst_n || !shift_clk) hi_q <= '0;
    else hi_q <= hi_q + 1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || enable_hi) low_q <= '0;
    else low_q <= low_q + 1;
  end
  // saturates so a stale pulse never looks recent
  always_ff @(posedge clk) begin
    if (!rst_n) fall_q <= 8'hff;
    else if ($fell(shift_clk)) fall_q <= 8'h00;
    else if (fall_q != 8'hff) fall_q <= fall_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !enable_hi) nbit_q <= 5'h00;
    else if ($rose(shift_clk)) nbit_q <= nbit_q + 5'h01;
  end
  // a selected phase without device drive is a programming phase
  always_ff @(posedge clk) begin
    if (!rst_n || enable_hi) dev_seen_q <= 1'b0;
    else if (data_dev_oe) dev_seen_q <= 1'b1;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_deselected;
    enable_hi [*8];
  endsequence
  sequence s_pulse_end;
    $fell(shift_clk);
  endsequence
  chk_line_released: assert property (s_deselected |-> !data_dev_oe)
    else $error("device drives line while deselected");
  chk_drive_after_pulse: assert property ($rose(data_dev_oe) |-> !enable_hi && fall_q <= 8'h08)
    else $error("device drive not tied to a pulse end");
  chk_rest_state: assert property ($rose(rst_n) |-> enable_hi && !shift_clk && !data_host_oe)
    else $error("link not at rest after reset");
  chk_clk_high_width: assert property (s_pulse_end |-> hi_q == HALF_CYC)
    else $error("clock high time wrong");
  chk_data_held: assert property (shift_clk && data_host_oe |-> $stable(data_host_o))
    else $error("host data moved while clock high");
  chk_enable_clk_low: assert property ($changed(enable_hi) |-> !shift_clk)
    else $error("enable moved while clock high");
  chk_cmd_length: assert property ($fell(enable_hi) |-> nbit_q inside {5'h00, 5'h08, 5'h10})
    else $error("wrong command bit count");
  chk_prog_time: assert property ($rose(enable_hi) && !dev_seen_q |-> low_q >= PROG_CYC)
    else $error("programming phase too short");
endmodule : tws_chk

// ===== test/tws_tb.sv
// bench: controller and memory joined over the link, driven over apb
`timescale 1ns/100ps
module tws_tb;
  localparam int HC = 4;
  localparam int PC = 50;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pg_act;
  logic        rd_act;
  logic [6:0]  la;
  logic [6:0]  la_s = 7'h00;
  int          pg_cyc = 0;
  int          rd_cyc = 0;
  logic [31:0] rdat;
  logic        perr;
  logic [6:0]  a;
  logic [6:0]  sa;
  logic [7:0]  d;
  logic [7:0]  sd;
  int          k;
  int          mem [128];
  int          fail_count;
  int          compares;

  tws_if tws_if_i ();
  tws_host #(.HALF_CYC(HC), .PROG_CYC(PC)) tws_host_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(tws_if_i));
  tws_device tws_device_i (.clk(clk), .rst_n(rst_n), .link(tws_if_i), .prog_active(pg_act),
    .read_active(rd_act), .last_addr(la));
  tws_chk #(.HALF_CYC(HC), .PROG_CYC(PC)) tws_chk_i (.clk(clk), .rst_n(rst_n),
    .enable_hi(tws_if_i.enable_hi), .shift_clk(tws_if_i.shift_clk),
    .data_host_o(tws_if_i.data_host_o), .data_host_oe(tws_if_i.data_host_oe),
    .data_dev_o(tws_if_i.data_dev_o), .data_dev_oe(tws_if_i.data_dev_oe),
    .data_line(tws_if_i.data_line));

  always #25 clk = ~clk;

  // device status levels are sampled mid-cycle, where they are settled
  always @(negedge clk) begin
    if (pg_act === 1'b1) pg_cyc++;
    if (rd_act === 1'b1) rd_cyc++;
    if (pg_act === 1'b1 || rd_act === 1'b1) la_s = la;
  end

  task automatic cmp_word(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag

  // entered just after a rising edge; one idle edge at the end avoids a double assign
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic run_op(input logic [1:0] op, input logic [6:0] wa, input logic [7:0] wd);
    int n;
    int p0;
    int r0;
    p0 = pg_cyc;
    r0 = rd_cyc;
    apb(1'b1, tws_pkg::REG_CMD, {8'h00, wd, 1'b0, wa, 6'h00, op});
    apb(1'b0, tws_pkg::REG_STATUS, 32'h0);
    cmp_flag(rdat[0], 1'b1);
    // must be ignored while busy
    apb(1'b1, tws_pkg::REG_CMD, {17'h0, wa, 6'h00, tws_pkg::OP_ERASE});
    n = 0;
    do begin
      apb(1'b0, tws_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 400);
    cmp_flag(rdat[0], 1'b0);
    apb(1'b0, tws_pkg::REG_CMD, 32'h0);
    cmp_word(rdat[7:0], {6'h00, op});
    cmp_flag(pg_cyc != p0, op != tws_pkg::OP_READ);
    cmp_flag(rd_cyc != r0, op == tws_pkg::OP_READ);
    cmp_word({1'b0, la_s}, {1'b0, (op == tws_pkg::OP_WRITE) ? sa : wa});
    if (op[0]) begin
      sa = wa;
      sd = op[1] ? wd : 8'hff;
      // erase raises the bits loaded as one
      mem[wa] = mem[wa] | sd;
    end
    if (op == tws_pkg::OP_WRITE) mem[sa] = mem[sa] & sd;
    if (op == tws_pkg::OP_READ) begin
      apb(1'b0, tws_pkg::REG_RDATA, 32'h0);
      cmp_word(rdat[7:0], 8'(mem[wa]));
    end
  endtask : run_op

  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    compares = 0;
    sa = 7'h00;
    sd = 8'hff;
    foreach (mem[i]) mem[i] = 8'hff;
    void'($urandom(83));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    cmp_flag(perr, 1'b1);
    cmp_word(rdat[7:0], 8'h00);
    run_op(tws_pkg::OP_READ, 7'h55, 8'h00);
    for (int i = 0; i < 9; i++) begin
      a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
      d = 8'($urandom);
      k = $urandom % 3;
      run_op((k == 1) ? tws_pkg::OP_ERASE : tws_pkg::OP_REPROG, a, d);
      if (k == 0) run_op(tws_pkg::OP_WRITE, a, d);
      run_op(tws_pkg::OP_READ, a, 8'h00);
    end
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule : tws_tb
